// ### rtl/gcfb_defs.vh
// Register offsets, field positions and reset values of the general configuration bank
`ifndef GCFB_DEFS_VH
`define GCFB_DEFS_VH
`define GCFB_ADDR_W          8
`define GCFB_OFS_COMBINE     8'h1b
`define GCFB_OFS_MODE        8'h1c
`define GCFB_OFS_MASK        8'h1d
`define GCFB_BIT_COMBINE     6
`define GCFB_RST_COMBINE     8'h00
`define GCFB_RST_MODE        2'h1
`define GCFB_RST_MASK        8'h0e
`define GCFB_MODE_OPERATE    2'h1
`define GCFB_MODE_CONFIG     2'h2
`define GCFB_BIT_OSC_MASK    0
`define GCFB_BIT_MON_MASK    1
`define GCFB_BIT_SAT1_MASK   2
`define GCFB_BIT_SAT2_MASK   3
`define GCFB_BIT_SIM_OVT     4
`define GCFB_BIT_SIM_OVC1    5
`define GCFB_BIT_SIM_OVC2    6
`define GCFB_BIT_SIM_OSC     7
`define GCFB_SAT_THR_0V5     2'h0
`endif

// ### rtl/gcfb_bank.v
// General configuration and fault mask bank with check output logic
`timescale 1ns/1ps
`include "gcfb_defs.vh"

module gcfb_bank
(
  input  wire       clk,
  input  wire       nrst,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata,
  input  wire [1:0] saturation_threshold_ch1,
  input  wire [1:0] saturation_threshold_ch2,
  input  wire [3:0] sat_above_ch1,
  input  wire [3:0] sat_above_ch2,
  input  wire       overtemp_event,
  input  wire       overcurrent_event_ch1,
  input  wire       overcurrent_event_ch2,
  input  wire       osc_watchdog_event,
  input  wire       monitor_event_ch1,
  input  wire       monitor_event_ch2,
  output reg        channel_combine,
  output reg        regulate_ch2,
  output reg        shutdown_ch1,
  output reg        shutdown_ch2,
  output reg        config_apply,
  output reg        driver_saturation_ch1,
  output reg        driver_saturation_ch2,
  output reg        fault_check_n
);

  reg  [7:0] combine_reg_r;
  reg  [1:0] chip_mode_select_r;
  reg  [7:0] mask_reg_r;
  reg        combine_latch_r;

  wire       osc_error_mask           = mask_reg_r[`GCFB_BIT_OSC_MASK];
  wire       monitor_event_mask       = mask_reg_r[`GCFB_BIT_MON_MASK];
  wire       saturation_mask_ch1      = mask_reg_r[`GCFB_BIT_SAT1_MASK];
  wire       saturation_mask_ch2      = mask_reg_r[`GCFB_BIT_SAT2_MASK];
  wire       overtemp_simulate        = mask_reg_r[`GCFB_BIT_SIM_OVT];
  wire       overcurrent_simulate_ch1 = mask_reg_r[`GCFB_BIT_SIM_OVC1];
  wire       overcurrent_simulate_ch2 = mask_reg_r[`GCFB_BIT_SIM_OVC2];
  wire       osc_error_simulate       = mask_reg_r[`GCFB_BIT_SIM_OSC];

  // Pick comparator output for threshold code; code 00 is 0.5 V
  function sat_pick;
    input [1:0] thr;
    input [3:0] above;
    begin
      case (thr)
        2'h0: sat_pick = above[0];
        2'h1: sat_pick = above[1];
        2'h2: sat_pick = above[2];
        default: sat_pick = above[3];
      endcase
    end
  endfunction

  wire ovt_any  = overtemp_event | overtemp_simulate;
  wire ovc1_any = overcurrent_event_ch1 | overcurrent_simulate_ch1;
  wire ovc2_any = overcurrent_event_ch2 | overcurrent_simulate_ch2;
  wire osc_any  = osc_watchdog_event | osc_error_simulate;
  wire sat1_nxt = sat_pick(saturation_threshold_ch1, sat_above_ch1);
  wire sat2_nxt = sat_pick(saturation_threshold_ch2, sat_above_ch2);

  wire osc_flag  = osc_any & ~osc_error_mask;
  wire mon_flag  = (monitor_event_ch1 | monitor_event_ch2) & ~monitor_event_mask;
  wire sat1_flag = sat1_nxt & ~saturation_mask_ch1;
  wire sat2_flag = sat2_nxt & ~saturation_mask_ch2;
  wire shut_flag = ovt_any | ovc1_any | ovc2_any;
  wire check_nxt = osc_flag | mon_flag | sat1_flag | sat2_flag | shut_flag;

  wire operate_mode = (chip_mode_select_r == `GCFB_MODE_OPERATE);

  reg  [7:0] combine_reg_nxt;
  reg  [1:0] chip_mode_select_nxt;
  reg  [7:0] mask_reg_nxt;
  reg  [7:0] rdata_nxt;
  reg        combine_latch_nxt;
  reg        shutdown_ch1_nxt;
  reg        shutdown_ch2_nxt;

  // Address match shared by write and read decode
  function reg_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      reg_hit = (a == ofs);
    end
  endfunction

  // Codes 00 and 11 are not allowed
  function mode_legal;
    input [1:0] code;
    begin
      mode_legal = (code == `GCFB_MODE_OPERATE) || (code == `GCFB_MODE_CONFIG);
    end
  endfunction

  // Next register contents after a write
  always @*
  begin
    combine_reg_nxt = combine_reg_r;
    if (wr_en && reg_hit(addr, `GCFB_OFS_COMBINE))
      combine_reg_nxt = wdata;
  end

  always @*
  begin
    chip_mode_select_nxt = chip_mode_select_r;
    if (wr_en && reg_hit(addr, `GCFB_OFS_MODE) && mode_legal(wdata[1:0]))
      chip_mode_select_nxt = wdata[1:0];
  end

  always @*
  begin
    mask_reg_nxt = mask_reg_r;
    if (wr_en && reg_hit(addr, `GCFB_OFS_MASK))
      mask_reg_nxt = wdata;
  end

  // Read data holds until the next read
  always @*
  begin
    rdata_nxt = rdata;
    if (rd_en)
    begin
      if (reg_hit(addr, `GCFB_OFS_COMBINE))
        rdata_nxt = combine_reg_r;
      else if (reg_hit(addr, `GCFB_OFS_MODE))
        rdata_nxt = {6'h00, chip_mode_select_r};
      else if (reg_hit(addr, `GCFB_OFS_MASK))
        rdata_nxt = mask_reg_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  always @*
  begin
    combine_latch_nxt = combine_latch_r;
    if (operate_mode)
      combine_latch_nxt = combine_reg_r[`GCFB_BIT_COMBINE];
  end

  // Combined channels share one power path
  always @*
  begin
    shutdown_ch1_nxt = ovt_any | ovc1_any;
    shutdown_ch2_nxt = ovt_any | ovc2_any;
    if (combine_latch_r)
    begin
      shutdown_ch1_nxt = shutdown_ch1_nxt | ovc2_any;
      shutdown_ch2_nxt = shutdown_ch2_nxt | ovc1_any;
    end
  end

  // Register bank
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      combine_reg_r <= `GCFB_RST_COMBINE;
    else
      combine_reg_r <= combine_reg_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      chip_mode_select_r <= `GCFB_RST_MODE;
    else
      chip_mode_select_r <= chip_mode_select_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mask_reg_r <= `GCFB_RST_MASK;
    else
      mask_reg_r <= mask_reg_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else
      rdata <= rdata_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      combine_latch_r <= 1'b0;
    else
      combine_latch_r <= combine_latch_nxt;
  end

  // Status outputs
  // low while configuration held
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      config_apply <= 1'b1;
    else
      config_apply <= operate_mode;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      channel_combine <= 1'b0;
    else
      channel_combine <= combine_latch_r;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      regulate_ch2 <= 1'b1;
    else
      regulate_ch2 <= ~combine_latch_r;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      shutdown_ch1 <= 1'b0;
    else
      shutdown_ch1 <= shutdown_ch1_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      shutdown_ch2 <= 1'b0;
    else
      shutdown_ch2 <= shutdown_ch2_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      driver_saturation_ch1 <= 1'b0;
    else
      driver_saturation_ch1 <= sat1_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      driver_saturation_ch2 <= 1'b0;
    else
      driver_saturation_ch2 <= sat2_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fault_check_n <= 1'b1;
    else
      fault_check_n <= ~check_nxt;
  end

endmodule

// ### verification/gcfb_bank_sva.sv
// Port assertions for the configuration bank
`timescale 1ns/1ps
module gcfb_sva
(
  input wire clk, nrst, wr_en, overtemp_event, overcurrent_event_ch1, overcurrent_event_ch2,
  input wire channel_combine, regulate_ch2, config_apply, shutdown_ch1, shutdown_ch2,
  input wire fault_check_n, driver_saturation_ch1,
  input wire [7:0] addr,
  input wire [1:0] saturation_threshold_ch1,
  input wire [3:0] sat_above_ch1
);
  wire mw = wr_en && addr == 8'h1c;
  wire s1 = sat_above_ch1[saturation_threshold_ch1];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ovt_flag_a: assert property (overtemp_event |=> !fault_check_n)
    else $error("no flag");
  ovt_shut_a: assert property (overtemp_event |=> shutdown_ch1 && shutdown_ch2)
    else $error("no shut");
  ovc_one_a: assert property (overcurrent_event_ch1 |=> shutdown_ch1)
    else $error("no shut 1");
  ovc_two_a: assert property (overcurrent_event_ch2 |=> shutdown_ch2)
    else $error("no shut 2");
  comb_reg_a: assert property (regulate_ch2 != channel_combine)
    else $error("bad reg");
  sat_lvl_a: assert property ($past(nrst) |-> driver_saturation_ch1 == $past(s1))
    else $error("bad sat");
  apply_why_a: assert property ($changed(config_apply) |-> $past(mw) || $past(mw, 2))
    else $error("bad apply");
  comb_hold_a: assert property ($changed(channel_combine) |-> $past(config_apply))
    else $error("bad hold");
  cover property (channel_combine);
  cover property (!config_apply);
  cover property (driver_saturation_ch1 ##1 !fault_check_n);
endmodule
bind gcfb_bank gcfb_sva u_sva (.*);

// ### verification/gcfb_bank_tb.sv
// Random and corner tests of the configuration bank
`timescale 1ns/1ps
module gcfb_bank_tb;
  reg clk = 0, nrst = 0, wr_en = 0, rd_en = 0;
  reg [7:0] addr = 0, wdata = 0, m;
  reg [17:0] e = 0;
  wire [7:0] rdata;
  wire channel_combine, regulate_ch2, shutdown_ch1, shutdown_ch2, config_apply;
  wire driver_saturation_ch1, driver_saturation_ch2, fault_check_n;
  integer seed = 24547, n_errors = 0, n_tests = 0, i;
  gcfb_bank dut (.*, .saturation_threshold_ch1(e[1:0]), .saturation_threshold_ch2(e[3:2]),
    .sat_above_ch1(e[7:4]), .sat_above_ch2(e[11:8]), .overtemp_event(e[12]),
    .overcurrent_event_ch1(e[13]), .overcurrent_event_ch2(e[14]),
    .osc_watchdog_event(e[15]), .monitor_event_ch1(e[16]), .monitor_event_ch2(e[17]));
  wire [7:0] obs = {3'h0, driver_saturation_ch2, driver_saturation_ch1,
    fault_check_n, shutdown_ch2, shutdown_ch1};
  wire [7:0] cmb = {5'h0, channel_combine, regulate_ch2, config_apply};
  always #5 clk = ~clk;
  task give_verdict;
    begin
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [47:0] n, input [7:0] s, x);
    begin
      n_tests = n_tests + 1;
      if (s !== x)
      begin
        n_errors = n_errors + 1;
        $display("wrong value %0s exp %h seen %h", n, x, s);
      end
    end
  endtask
  task rw(input w, input [7:0] a, d);
    begin
      @(posedge clk);
      {wr_en, rd_en, addr, wdata} <= {w, !w, a, d};
      @(posedge clk);
      {wr_en, rd_en} <= 2'h0;
      #1;
      if (!w)
        chk("rdata", rdata, d);
    end
  endtask
  function [7:0] ex(input [17:0] v, input [7:0] k);
    reg f;
    begin
      f = (|v[14:12]) | (|k[6:4]) | (v[15] | k[7]) & !k[0] | (v[16] | v[17]) & !k[1]
        | v[4 + v[1:0]] & !k[2] | v[8 + v[3:2]] & !k[3];
      ex = {3'h0, v[8 + v[3:2]], v[4 + v[1:0]], !f, v[12] | k[4] | v[14] | k[6],
        v[12] | k[4] | v[13] | k[5]};
    end
  endfunction
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    rw(1'h0, 8'h1b, 8'h00);
    rw(1'h0, 8'h1d, 8'h0e);
    rw(1'h1, 8'h1c, 8'h00);
    rw(1'h1, 8'h1c, 8'h03);
    rw(1'h1, 8'h2a, 8'h55);
    rw(1'h0, 8'h1c, 8'h01);
    rw(1'h0, 8'h2a, 8'h00);
    $display("done regs");
    rw(1'h1, 8'h1b, 8'h40);
    repeat (4) @(posedge clk);
    #1 chk("comb", cmb, 8'h05);
    rw(1'h1, 8'h1c, 8'h02);
    rw(1'h1, 8'h1b, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk("hold", cmb, 8'h04);
    rw(1'h1, 8'h1c, 8'h01);
    repeat (4) @(posedge clk);
    #1 chk("split", cmb, 8'h03);
    $display("done combine");
    for (i = 0; i < 40; i = i + 1)
    begin
      m = (i < 2) ? {8{i[0]}} : $random(seed);
      if (i[0])
        m = m & 8'h0f;
      @(posedge clk) e <= i[0] ? $random(seed) & 18'hfff : $random(seed) & $random(seed);
      rw(1'h1, 8'h1d, m);
      repeat (4) @(posedge clk);
      #1 chk("faults", obs, ex(e, m));
      rw(1'h0, 8'h1d, m);
    end
    $display("done faults");
    rw(1'h1, 8'h1b, 8'h40);
    @(posedge clk) e <= 18'h02000;
    rw(1'h1, 8'h1d, 8'h0e);
    repeat (4) @(posedge clk);
    #1 chk("merged", obs, 8'h03);
    $display("done merged");
    give_verdict;
  end
  initial
  begin
    #60000;
    n_errors = n_errors + 1;
    give_verdict;
  end
endmodule
